/* design/cbt_defines.vh */
// constants for the card block transfer controller
`ifndef CBT_DEFINES_VH
`define CBT_DEFINES_VH
// transfer states
`define CBT_ST_IDLE     4'h0
`define CBT_ST_RD_START 4'h1
`define CBT_ST_RD_DATA  4'h2
`define CBT_ST_RD_CRC   4'h3
`define CBT_ST_RD_END   4'h4
`define CBT_ST_RD_HOLD  4'h5
`define CBT_ST_WR_WAIT  4'h6
`define CBT_ST_WR_DATA  4'h7
`define CBT_ST_WR_CRC   4'h8
`define CBT_ST_WR_END   4'h9
`define CBT_ST_WR_STAT  4'hA
`define CBT_ST_WR_IGN   4'hB
// command indices
`define CBT_CMD_RESET   6'h00
`define CBT_CMD_SWITCH  6'h06
`define CBT_CMD_SELECT  6'h07
`define CBT_CMD_STOP    6'h0C
`define CBT_CMD_STATUS  6'h0D
`define CBT_CMD_BLKLEN  6'h10
`define CBT_CMD_RD_ONE  6'h11
`define CBT_CMD_RD_MUL  6'h12
`define CBT_CMD_BLKCNT  6'h17
`define CBT_CMD_WR_ONE  6'h18
`define CBT_CMD_WR_MUL  6'h19
`define CBT_CMD_PRG_CSD 6'h1B
// data line count selection byte: index, reset value, encodings
`define CBT_BW_INDEX    8'hB7
`define CBT_BW_RESET    8'h00
`define CBT_BW_1        8'h00
`define CBT_BW_4        8'h01
`define CBT_BW_8        8'h02
`define CBT_IDX_LIMIT   8'hBF
`define CBT_ACC_WRBYTE  2'h3
// response status bit positions
`define CBT_RS_ILLEGAL  0
`define CBT_RS_RANGE    1
`define CBT_RS_BLEN     2
`define CBT_RS_ALIGN    3
`define CBT_RS_CRC      4
`define CBT_RS_SWITCH   5
`define CBT_RS_GENERAL  6
`define CBT_RS_READY    7
`define CBT_RS_SELECTED 12
// framing and checksum
`define CBT_CRC_POLY    16'h1021
`define CBT_CRC_LAST    4'hF
`define CBT_TOK_LAST    4'h5
`define CBT_CSD_BYTES   12'h010
`define CBT_BLEN_RESET  12'h200
`endif

/* design/cbt_block_transfer.v */
// card side block transfer controller with per-line crc and write buffer
//
// Behaviour
// - data line count byte resets to 0x00 at power-on and soft reset
// - undefined value written to line count byte: keep byte, raise switch fault
// - line count byte is write only, never read back
// - data lines high when idle; all transfers on link clock edges
// - block: low start bit, payload, per-line crc, high end bit
// - read length capped at max size; shorter only with partial reads allowed
// - single block read sends one block then returns to transfer state
// - open-ended multi read or write runs until stop command
// - block count command before multi command gives counted transfer
// - zero block count gives open-ended transfer needing stop
// - stop command accepted anywhere in multi transfer, aborts it
// - bad address, length or alignment rejects command, stays in transfer
// - read error mid transfer: stop sending; multi read stays in data, reports at stop; single read returns to transfer
// - stop after counted transfer completed is illegal command
// - misaligned partial read flags alignment fault; stop returns to transfer
// - crc checked before programming; failure signalled, block dropped, rest ignored
// - write error mid transfer: ignore blocks, stay receiving, report at stop
// - stopped counted write leaves remaining blocks undefined
// - misaligned partial write aborts, ignores data; stop reports alignment fault
// - config record write needs no length; read-only part mismatch is error
// - hold first line low while buffer busy; status poll shows buffer free
// - deselect releases first line; reselect resumes busy if still busy
`timescale 1ns/1ps
`include "cbt_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// one line's checksum; feeding its own msb shifts it out while zeroing
module cbt_crc16 (
	input  wire        core_clk,
	input  wire        arst_n,
	input  wire        clr,
	input  wire        en,
	input  wire        din,
	output reg  [15:0] crc
);
	wire fb = crc[15] ^ din;

	// serial crc, msb first
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			crc <= 16'h0000;
		else if (clr)
			crc <= 16'h0000;
		else if (en)
			crc <= {crc[14:0], 1'b0} ^ (fb ? `CBT_CRC_POLY : 16'h0000);
	end
endmodule // cbt_crc16

////////////////////////////////////////////////////////////////////////////////
// write buffer between the link and the memory port
module cbt_fifo #(
	parameter W = 8,
	parameter D = 8
) (
	input  wire         core_clk,
	input  wire         arst_n,
	input  wire         clr,
	input  wire [W-1:0] in_data,
	input  wire         in_valid,
	output wire         in_ready,
	output wire [W-1:0] out_data,
	output wire         out_valid,
	input  wire         out_ready
);
	localparam AW = (D > 1) ? $clog2(D) : 1;
	localparam [AW:0] DEPTH = D;

	reg [W-1:0]  mem_r [0:D-1];
	reg [AW-1:0] wp_r;
	reg [AW-1:0] rp_r;
	reg [AW:0]   cnt_r;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (cnt_r != DEPTH);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data  = mem_r[rp_r];

	// pointers wrap at depth, count tells full from empty
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else if (clr) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp_r <= (wp_r == D - 1) ? {AW{1'b0}} : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == D - 1) ? {AW{1'b0}} : rp_r + 1'b1;
			cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end

	// storage has no reset, only the pointers and the count need one
	always @(posedge core_clk) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end
endmodule // cbt_fifo

////////////////////////////////////////////////////////////////////////////////
// transfer controller
module cbt_block_transfer #(
	parameter         MAX_RD_LOG2 = 9,
	parameter [31:0]  CAPACITY    = 32'h0100_0000,
	parameter [15:0]  RCA         = 16'h0001,
	parameter [127:0] CSD_INIT    = 128'h0,
	parameter         FIFO_DEPTH  = 8
) (
	input  wire         core_clk,
	input  wire         arst_n,
	input  wire         cmd_valid,
	input  wire [5:0]   cmd_index,
	input  wire [31:0]  cmd_arg,
	output reg          resp_valid,
	output reg  [15:0]  resp_status,
	input  wire         link_clk,
	input  wire [7:0]   dat_in,
	output reg  [7:0]   dat_out,
	output reg  [7:0]   dat_oe_n,
	input  wire         partial_read_allowed,
	input  wire         rd_misalign_allowed,
	input  wire         write_misalign_allowed,
	output reg  [31:0]  mem_addr,
	input  wire [7:0]   mem_rd_data,
	input  wire         mem_rd_valid,
	output wire         mem_rd_ready,
	output wire [7:0]   mem_wr_data,
	output wire         mem_wr_valid,
	input  wire         mem_wr_ready,
	output reg          mem_commit,
	output reg          mem_discard,
	input  wire         mem_busy,
	output reg  [127:0] csd_value
);
	localparam [12:0] MAXL = 13'h1 << MAX_RD_LOG2;

	reg         lc_s1, lc_s2, lc_s3;
	reg [7:0]   dat_s1, dat_s2;
	reg [3:0]   state_r, state_nxt;
	reg [3:0]   sub_r, sub_nxt;
	reg [11:0]  bcnt_r, bcnt_nxt;
	reg [7:0]   sh_r, sh_nxt;
	reg [31:0]  addr_nxt;
	reg [11:0]  blen_r, blen_nxt;
	reg [15:0]  left_r, left_nxt;
	reg [15:0]  pend_r, pend_nxt;
	reg         pendv_r, pendv_nxt;
	reg         counted_r, counted_nxt;
	reg         multi_r, multi_nxt;
	reg         csdm_r, csdm_nxt;
	reg         bad_r, bad_nxt;
	reg         sel_r, sel_nxt;
	reg [7:0]   mode_r, mode_nxt;
	reg [6:0]   err_r, err_nxt;
	reg [6:0]   cerr;
	reg [127:0] csd_sh_r, csd_sh_nxt;
	reg [127:0] csd_nxt;
	reg [7:0]   out_nxt, oen_nxt;
	reg         resp_v_nxt;
	reg [15:0]  resp_nxt;
	reg         commit_nxt, discard_nxt;
	reg         load, push, crc_clr, crc_en;
	reg [7:0]   crc_din;

	wire        rise = lc_s2 & ~lc_s3;
	wire        busy = mem_wr_valid | mem_busy;
	wire        fifo_rdy;
	wire [127:0] crc_v;
	wire [7:0]  crc_msb;
	wire [7:0]  crc_zero;

	// line count selection steers framing; byte itself is never read back
	wire is8 = (mode_r == `CBT_BW_8);
	wire is4 = (mode_r == `CBT_BW_4);
	wire [7:0] act     = is8 ? 8'hFF : (is4 ? 8'h0F : 8'h01);
	wire [3:0] lastsub = is8 ? 4'h0 : (is4 ? 4'h1 : 4'h7);
	wire [7:0] tx_bits = is8 ? sh_r : (is4 ? {4'hF, sh_r[7:4]} : {7'h7F, sh_r[7]});
	wire [7:0] tx_rest = is8 ? 8'hFF : (is4 ? {sh_r[3:0], 4'hF} : {sh_r[6:0], 1'b1});
	wire [7:0] rx_byte = is8 ? dat_s2 : (is4 ? {sh_r[3:0], dat_s2[3:0]}
	                                        : {sh_r[6:0], dat_s2[0]});
	wire       crc_ok  = &crc_zero;
	wire [11:0] blk_len = csdm_r ? `CBT_CSD_BYTES : blen_r;

	// argument checks for a new read or write
	wire [12:0] cmd_off = {1'b0, cmd_arg[11:0]} & (MAXL - 13'h1);
	wire al_bad_c   = (cmd_off + {1'b0, blen_r}) > MAXL;
	wire bl_bad     = (blen_r == 12'h000) || ({1'b0, blen_r} > MAXL);
	wire rd_bl_bad  = bl_bad | (({1'b0, blen_r} != MAXL) & ~partial_read_allowed);
	wire wr_bl_bad  = bl_bad | (({1'b0, blen_r} != MAXL) & ~write_misalign_allowed);
	wire rng_bad_c  = (cmd_arg >= CAPACITY);

	// checks on the block that follows in a multi transfer
	wire [31:0] nxt_addr = mem_addr + {20'h00000, blen_r};
	wire [12:0] nxt_off  = {1'b0, nxt_addr[11:0]} & (MAXL - 13'h1);
	wire nxt_mis  = (nxt_off + {1'b0, blen_r}) > MAXL;
	wire nxt_oor  = (nxt_addr >= CAPACITY);
	wire last_blk = ~multi_r | (counted_r & (left_r == 16'h0001));
	wire [4:0] tokv = {1'b0, bad_r ? 3'b101 : 3'b010, 1'b1};

	assign mem_rd_ready = load;

	////////////////////////////////////////////////////////////////////////////
	// link clock and data pins are foreign: two flops, then edge detect
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			lc_s1  <= 1'b0;
			lc_s2  <= 1'b0;
			lc_s3  <= 1'b0;
			dat_s1 <= 8'hFF;
			dat_s2 <= 8'hFF;
		end else begin
			lc_s1  <= link_clk;
			lc_s2  <= lc_s1;
			lc_s3  <= lc_s2;
			dat_s1 <= dat_in;
			dat_s2 <= dat_s1;
		end
	end

	// one checksum per data line
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_crc
			cbt_crc16 u_crc (
				.core_clk (core_clk),
				.arst_n   (arst_n),
				.clr      (crc_clr),
				.en       (crc_en),
				.din      (crc_din[g]),
				.crc      (crc_v[g*16 +: 16])
			);
			assign crc_msb[g]  = crc_v[g*16 + 15];
			assign crc_zero[g] = ~act[g] | (crc_v[g*16 +: 16] == 16'h0000);
		end
	endgenerate

	// write buffer; overrun cannot stall the host, so it fails the block
	cbt_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.clr       (discard_nxt),
		.in_data   (rx_byte),
		.in_valid  (push),
		.in_ready  (fifo_rdy),
		.out_data  (mem_wr_data),
		.out_valid (mem_wr_valid),
		.out_ready (mem_wr_ready)
	);

	////////////////////////////////////////////////////////////////////////////
	// transfer engine and command handling
	always @* begin
		state_nxt = state_r;   sub_nxt = sub_r;       bcnt_nxt = bcnt_r;
		sh_nxt = sh_r;         addr_nxt = mem_addr;   blen_nxt = blen_r;
		left_nxt = left_r;     pend_nxt = pend_r;     pendv_nxt = pendv_r;
		counted_nxt = counted_r; multi_nxt = multi_r; csdm_nxt = csdm_r;
		bad_nxt = bad_r;       sel_nxt = sel_r;       mode_nxt = mode_r;
		csd_sh_nxt = csd_sh_r; csd_nxt = csd_value;
		out_nxt = dat_out;     oen_nxt = dat_oe_n;
		err_nxt = 7'h00;       cerr = 7'h00;
		resp_v_nxt = 1'b0;     resp_nxt = resp_status;
		commit_nxt = 1'b0;     discard_nxt = 1'b0;
		load = 1'b0;  push = 1'b0;  crc_clr = 1'b0;  crc_en = 1'b0;
		crc_din = dat_s2;
		if (rise) begin
			case (state_r)
			`CBT_ST_RD_START: begin
				out_nxt = ~act;
				oen_nxt = ~act;
				crc_clr = 1'b1;
				sub_nxt = 4'h0;
				bcnt_nxt = 12'h000;
				load = mem_rd_valid;
				sh_nxt = mem_rd_data;
				state_nxt = `CBT_ST_RD_DATA;
			end
			`CBT_ST_RD_DATA: begin
				out_nxt = tx_bits;
				crc_en = 1'b1;
				crc_din = tx_bits;
				sh_nxt = tx_rest;
				sub_nxt = sub_r + 4'h1;
				if (sub_r == lastsub) begin
					sub_nxt = 4'h0;
					bcnt_nxt = bcnt_r + 12'h001;
					if (bcnt_r == blen_r - 12'h001)
						state_nxt = `CBT_ST_RD_CRC;
					else if (mem_rd_valid) begin
						load = 1'b1;
						sh_nxt = mem_rd_data;
					end else begin
						// source starved: quit sending; multi read stays for stop, single read returns idle
						err_nxt[`CBT_RS_GENERAL] = 1'b1;
						out_nxt = 8'hFF;
						oen_nxt = 8'hFF;
						state_nxt = multi_r ? `CBT_ST_RD_HOLD : `CBT_ST_IDLE;
					end
				end
			end
			`CBT_ST_RD_CRC: begin
				out_nxt = crc_msb | ~act;
				crc_en = 1'b1;
				crc_din = crc_msb;
				sub_nxt = sub_r + 4'h1;
				if (sub_r == `CBT_CRC_LAST) begin
					sub_nxt = 4'h0;
					state_nxt = `CBT_ST_RD_END;
				end
			end
			`CBT_ST_RD_END: begin
				out_nxt = 8'hFF;
				sub_nxt = 4'h1;
				if (sub_r != 4'h0) begin
					oen_nxt = 8'hFF;
					if (last_blk)
						state_nxt = `CBT_ST_IDLE;
					else if (~rd_misalign_allowed & nxt_mis) begin
						err_nxt[`CBT_RS_ALIGN] = 1'b1;
						state_nxt = `CBT_ST_RD_HOLD;
					end else if (nxt_oor) begin
						err_nxt[`CBT_RS_RANGE] = 1'b1;
						state_nxt = `CBT_ST_RD_HOLD;
					end else begin
						addr_nxt = nxt_addr;
						left_nxt = left_r - 16'h0001;
						state_nxt = `CBT_ST_RD_START;
					end
				end
			end
			`CBT_ST_WR_WAIT: begin
				// busy drive on line 0 must not look like a start bit
				if (~dat_s2[0] & dat_oe_n[0]) begin
					crc_clr = 1'b1;
					sub_nxt = 4'h0;
					bcnt_nxt = 12'h000;
					bad_nxt = 1'b0;
					state_nxt = `CBT_ST_WR_DATA;
				end
			end
			`CBT_ST_WR_DATA: begin
				crc_en = 1'b1;
				sh_nxt = rx_byte;
				sub_nxt = sub_r + 4'h1;
				if (sub_r == lastsub) begin
					sub_nxt = 4'h0;
					bcnt_nxt = bcnt_r + 12'h001;
					if (csdm_r)
						csd_sh_nxt = {csd_sh_r[119:0], rx_byte};
					else if (~bad_r) begin
						push = 1'b1;
						if (~fifo_rdy) begin
							err_nxt[`CBT_RS_GENERAL] = 1'b1;
							bad_nxt = 1'b1;
						end
					end
					if (bcnt_r == blk_len - 12'h001)
						state_nxt = `CBT_ST_WR_CRC;
				end
			end
			`CBT_ST_WR_CRC: begin
				crc_en = 1'b1;
				sub_nxt = sub_r + 4'h1;
				if (sub_r == `CBT_CRC_LAST)
					state_nxt = `CBT_ST_WR_END;
			end
			`CBT_ST_WR_END: begin
				// checksum residue must be zero and end bits high
				if (~crc_ok | ((dat_s2 & act) != act)) begin
					bad_nxt = 1'b1;
					err_nxt[`CBT_RS_CRC] = 1'b1;
				end
				sub_nxt = 4'h0;
				state_nxt = `CBT_ST_WR_STAT;
			end
			`CBT_ST_WR_STAT: begin
				sub_nxt = sub_r + 4'h1;
				oen_nxt[0] = 1'b0;
				out_nxt[0] = tokv[3'h4 - sub_r[2:0]];
				if (sub_r == `CBT_TOK_LAST) begin
					out_nxt[0] = 1'b1;
					oen_nxt[0] = 1'b1;
					if (bad_r) begin
						discard_nxt = 1'b1;
						state_nxt = multi_r ? `CBT_ST_WR_IGN : `CBT_ST_IDLE;
					end else begin
						if (csdm_r) begin
							if (csd_sh_r[127:16] == csd_value[127:16])
								csd_nxt = csd_sh_r;
							else
								err_nxt[`CBT_RS_GENERAL] = 1'b1;
						end else
							commit_nxt = 1'b1;
						if (last_blk | csdm_r)
							state_nxt = `CBT_ST_IDLE;
						else if (~write_misalign_allowed & nxt_mis) begin
							err_nxt[`CBT_RS_ALIGN] = 1'b1;
							state_nxt = `CBT_ST_WR_IGN;
						end else if (nxt_oor) begin
							err_nxt[`CBT_RS_RANGE] = 1'b1;
							state_nxt = `CBT_ST_WR_IGN;
						end else begin
							addr_nxt = nxt_addr;
							left_nxt = left_r - 16'h0001;
							state_nxt = `CBT_ST_WR_WAIT;
						end
					end
				end
			end
			default: begin
			end
			endcase
		end
		if (cmd_valid) begin
			resp_v_nxt = 1'b1;
			pendv_nxt = 1'b0;
			case (cmd_index)
			`CBT_CMD_RESET: begin
				mode_nxt = `CBT_BW_RESET;
				state_nxt = `CBT_ST_IDLE;
				sel_nxt = 1'b0;
				blen_nxt = `CBT_BLEN_RESET;
				out_nxt = 8'hFF;
				oen_nxt = 8'hFF;
			end
			`CBT_CMD_STATUS: begin
			end
			`CBT_CMD_SELECT: begin
				if (state_r == `CBT_ST_IDLE)
					sel_nxt = (cmd_arg[31:16] == RCA);
				else
					cerr[`CBT_RS_ILLEGAL] = 1'b1;
			end
			`CBT_CMD_STOP: begin
				if (state_r == `CBT_ST_IDLE)
					cerr[`CBT_RS_ILLEGAL] = 1'b1;
				else begin
					// stop mid block drops the partial write
					if (state_r >= `CBT_ST_WR_DATA && state_r <= `CBT_ST_WR_STAT)
						discard_nxt = 1'b1;
					state_nxt = `CBT_ST_IDLE;
					out_nxt = 8'hFF;
					oen_nxt = 8'hFF;
				end
			end
			default: begin
				if (state_r != `CBT_ST_IDLE || !sel_r)
					cerr[`CBT_RS_ILLEGAL] = 1'b1;
				else begin
					case (cmd_index)
					`CBT_CMD_SWITCH: begin
						if (cmd_arg[25:24] == `CBT_ACC_WRBYTE) begin
							if (cmd_arg[23:16] > `CBT_IDX_LIMIT)
								cerr[`CBT_RS_SWITCH] = 1'b1;
							else if (cmd_arg[23:16] == `CBT_BW_INDEX) begin
								if (cmd_arg[15:8] <= `CBT_BW_8)
									mode_nxt = cmd_arg[15:8];
								else
									cerr[`CBT_RS_SWITCH] = 1'b1;
							end
						end
					end
					`CBT_CMD_BLKLEN: blen_nxt = cmd_arg[11:0];
					`CBT_CMD_BLKCNT: begin
						pend_nxt = cmd_arg[15:0];
						pendv_nxt = 1'b1;
					end
					`CBT_CMD_RD_ONE, `CBT_CMD_RD_MUL,
					`CBT_CMD_WR_ONE, `CBT_CMD_WR_MUL: begin
						cerr[`CBT_RS_RANGE] = rng_bad_c;
						cerr[`CBT_RS_BLEN] = cmd_index[3] ? wr_bl_bad : rd_bl_bad;
						cerr[`CBT_RS_ALIGN] = ~rng_bad_c & al_bad_c & ~bl_bad &
							~(cmd_index[3] ? write_misalign_allowed : rd_misalign_allowed);
						if (cerr == 7'h00) begin
							addr_nxt = cmd_arg;
							multi_nxt = ~(cmd_index[0] ^ cmd_index[3]);
							counted_nxt = pendv_r & (pend_r != 16'h0000);
							left_nxt = pend_r;
							csdm_nxt = 1'b0;
							sub_nxt = 4'h0;
							state_nxt = cmd_index[3] ? `CBT_ST_WR_WAIT : `CBT_ST_RD_START;
						end
					end
					`CBT_CMD_PRG_CSD: begin
						csdm_nxt = 1'b1;
						multi_nxt = 1'b0;
						state_nxt = `CBT_ST_WR_WAIT;
					end
					default: cerr[`CBT_RS_ILLEGAL] = 1'b1;
					endcase
				end
			end
			endcase
			// report pending faults, then keep only those raised this cycle
			resp_nxt = {3'h0, sel_nxt, state_nxt, ~busy, err_r | cerr};
		end else begin
			// no answer this cycle: pending faults stay, new ones join them
			err_nxt = err_nxt | err_r;
		end
		// busy on line 0 only while selected and not framing
		if (state_nxt == `CBT_ST_IDLE || state_nxt == `CBT_ST_WR_WAIT) begin
			oen_nxt[0] = ~(sel_nxt & busy);
			out_nxt[0] = ~(sel_nxt & busy);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state and output registers
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= `CBT_ST_IDLE;  sub_r <= 4'h0;      bcnt_r <= 12'h000;
			sh_r <= 8'hFF;            mem_addr <= 32'h0;  blen_r <= `CBT_BLEN_RESET;
			left_r <= 16'h0000;       pend_r <= 16'h0000; pendv_r <= 1'b0;
			counted_r <= 1'b0;        multi_r <= 1'b0;    csdm_r <= 1'b0;
			bad_r <= 1'b0;            sel_r <= 1'b0;
			mode_r <= `CBT_BW_RESET;
			err_r <= 7'h00;           csd_sh_r <= 128'h0; csd_value <= CSD_INIT;
			dat_out <= 8'hFF;         dat_oe_n <= 8'hFF;
			resp_valid <= 1'b0;       resp_status <= 16'h0000;
			mem_commit <= 1'b0;       mem_discard <= 1'b0;
		end else begin
			state_r <= state_nxt;     sub_r <= sub_nxt;   bcnt_r <= bcnt_nxt;
			sh_r <= sh_nxt;           mem_addr <= addr_nxt; blen_r <= blen_nxt;
			left_r <= left_nxt;       pend_r <= pend_nxt; pendv_r <= pendv_nxt;
			counted_r <= counted_nxt; multi_r <= multi_nxt; csdm_r <= csdm_nxt;
			bad_r <= bad_nxt;         sel_r <= sel_nxt;   mode_r <= mode_nxt;
			err_r <= err_nxt;         csd_sh_r <= csd_sh_nxt; csd_value <= csd_nxt;
			dat_out <= out_nxt;       dat_oe_n <= oen_nxt;
			resp_valid <= resp_v_nxt; resp_status <= resp_nxt;
			mem_commit <= commit_nxt; mem_discard <= discard_nxt;
		end
	end
endmodule // cbt_block_transfer

/* test/cbt_block_transfer_properties.sv */
// port checker for the block transfer controller
`timescale 1ns/1ps
module cbt_block_transfer_properties #(
	parameter [31:0] CAPACITY = 32'h0100_0000
) (
	input wire        core_clk,
	input wire        arst_n,
	input wire        cmd_valid,
	input wire [5:0]  cmd_index,
	input wire [31:0] cmd_arg,
	input wire        partial_read_allowed,
	input wire        resp_valid,
	input wire [15:0] resp_status,
	input wire [7:0]  dat_out,
	input wire [7:0]  dat_oe_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	reg  [11:0] blen_r;
	wire        rd_cmd;
	wire        sw_cmd;
	////////////////////////////////////////////////////////////////////////////
	// block length as last set while selected; soft reset gives 512 again
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			blen_r <= 12'h200;
		else if (cmd_valid && cmd_index == 6'h00)
			blen_r <= 12'h200;
		else if (cmd_valid && cmd_index == 6'h10 && resp_status[12])
			blen_r <= cmd_arg[11:0];
	end
	// reads met while selected and with the bus released; switches met while selected
	assign rd_cmd = cmd_valid && resp_status[12] && (&dat_oe_n)
		&& (cmd_index == 6'h11 || cmd_index == 6'h12);
	assign sw_cmd = cmd_valid && resp_status[12] && cmd_arg[25:16] == 10'h3B7
		&& cmd_index == 6'h06;
	////////////////////////////////////////////////////////////////////////////
	chk_resp_follows: assert property (cmd_valid |=> resp_valid)
		else $error("no response one cycle after a command");
	chk_resp_causeless: assert property (!cmd_valid |=> !resp_valid)
		else $error("response without a command");
	chk_status_held: assert property (!resp_valid |-> $stable(resp_status))
		else $error("status changed between responses");
	chk_range_reject: assert property (rd_cmd && cmd_arg >= CAPACITY
		|=> resp_status[1] && resp_status[11:8] == 4'h0)
		else $error("out of range read not rejected");
	chk_range_quiet: assert property (rd_cmd && cmd_arg >= CAPACITY
		|=> (dat_oe_n == 8'hFF) [*8])
		else $error("rejected read drove the bus");
	chk_blen_reject: assert property (rd_cmd && cmd_arg < CAPACITY
		&& blen_r < 12'h200 && !partial_read_allowed |=> resp_status[2])
		else $error("short block read accepted without partial flag");
	chk_switch_bad: assert property (sw_cmd && cmd_arg[15:8] > 8'h02
		|=> resp_status[5])
		else $error("undefined line count value not flagged");
	chk_switch_good: assert property (sw_cmd && cmd_arg[15:8] <= 8'h02
		|=> !resp_status[5])
		else $error("defined line count value flagged");
	chk_start_low: assert property ($fell(dat_oe_n[0]) |-> !dat_out[0])
		else $error("first data line taken without a low level");
endmodule // cbt_block_transfer_properties

bind cbt_block_transfer cbt_block_transfer_properties #(.CAPACITY(CAPACITY)) u_chk (
	.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
	.cmd_index(cmd_index), .cmd_arg(cmd_arg), .partial_read_allowed(partial_read_allowed),
	.resp_valid(resp_valid), .resp_status(resp_status), .dat_out(dat_out),
	.dat_oe_n(dat_oe_n));

/* test/cbt_host_model.sv */
// host side model: bus clock within frames, pulled-up data lines
`timescale 1ns/1ps
module cbt_host_model (
	input  wire       run,
	input  wire [7:0] dat_out,
	input  wire [7:0] dat_oe_n,
	output reg        link_clk,
	output wire [7:0] dat_in
);
	// clock stands low between frames; odd offset keeps it off core edges
	initial begin
		link_clk = 1'b0;
		#13;
		forever begin
			#100;
			link_clk = run ? ~link_clk : 1'b0;
		end
	end
	// host never drives here, so a released line sits at its pull-up
	assign dat_in = dat_out | dat_oe_n;
endmodule // cbt_host_model

/* test/cbt_block_transfer_tb.sv */
// self-checking bench for the block transfer controller
`timescale 1ns/1ps
module cbt_block_transfer_tb;
	reg         core_clk;
	reg         arst_n;
	reg         cmd_valid;
	reg  [5:0]  cmd_index;
	reg  [31:0] cmd_arg;
	reg         partial_read_allowed;
	reg  [7:0]  mem_rd_data;
	reg         run;
	wire        resp_valid;
	wire [15:0] resp_status;
	wire        link_clk;
	wire [7:0]  dat_in;
	wire [7:0]  dat_out;
	wire [7:0]  dat_oe_n;
	wire        mem_rd_ready;
	integer     mismatches;
	integer     num_checks;
	////////////////////////////////////////////////////////////////////////////
	cbt_block_transfer DUT (
		.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
		.cmd_index(cmd_index), .cmd_arg(cmd_arg), .resp_valid(resp_valid),
		.resp_status(resp_status), .link_clk(link_clk), .dat_in(dat_in),
		.dat_out(dat_out), .dat_oe_n(dat_oe_n),
		.partial_read_allowed(partial_read_allowed), .rd_misalign_allowed(1'b0),
		.write_misalign_allowed(1'b0), .mem_addr(), .mem_rd_data(mem_rd_data),
		.mem_rd_valid(1'b1), .mem_rd_ready(mem_rd_ready), .mem_wr_data(),
		.mem_wr_valid(), .mem_wr_ready(1'b1), .mem_commit(), .mem_discard(),
		.mem_busy(1'b0), .csd_value());
	cbt_host_model HOST (.run(run), .dat_out(dat_out), .dat_oe_n(dat_oe_n),
		.link_clk(link_clk), .dat_in(dat_in));
	// 40 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// memory source steps its byte on each take, so a lost or extra fetch shows
	always @(posedge core_clk) begin
		if (mem_rd_ready)
			mem_rd_data <= mem_rd_data + 8'h01;
	end
	////////////////////////////////////////////////////////////////////////////
	task chk_bits(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
			end
		end
	endtask
	// one command for one cycle, answer seen just after it drops; no write pending, so buffer free
	task cmd(input [5:0] idx, input [31:0] arg, input [15:0] exp);
		begin
			@(posedge core_clk);
			cmd_valid <= 1'b1;
			cmd_index <= idx;
			cmd_arg <= arg;
			@(posedge core_clk);
			cmd_valid <= 1'b0;
			#1;
			chk_bits({15'h0, resp_valid, resp_status & 16'h1FFF}, {16'h1, exp | 16'h0080});
		end
	endtask
	function [15:0] crc16(input [7:0] d);
		integer i;
		begin
			crc16 = 16'h0000;
			for (i = 7; i >= 0; i = i - 1)
				crc16 = {crc16[14:0], 1'b0} ^ ((crc16[15] ^ d[i]) ? 16'h1021 : 16'h0000);
		end
	endfunction
	// one block seen on line ln over n link edges: idle, start, data, crc, end
	task frame(input [2:0] ln, input [5:0] n, input [31:0] exp);
		reg [31:0] v;
		begin
			v = 32'h0;
			@(posedge core_clk);
			run <= 1'b1;
			repeat (n) begin
				@(posedge link_clk);
				v = {v[30:0], dat_in[ln]};
			end
			@(posedge core_clk);
			run <= 1'b0;
			repeat (6) @(posedge core_clk);
			chk_bits(v, exp);
			chk_bits({24'h0, dat_oe_n}, 32'hFF);
		end
	endtask
	task conclude;
		begin
			if (mismatches == 0 && num_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		mismatches = mismatches + 1;
		conclude;
	end
	initial begin
		mismatches = 0;
		num_checks = 0;
		arst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_index = 6'h00;
		cmd_arg = 32'h0;
		partial_read_allowed = 1'b0;
		mem_rd_data = 8'hA5;
		run = 1'b0;
		repeat (16) @(posedge core_clk);
		chk_bits({dat_oe_n, dat_out, resp_status}, 32'hFFFF_0000);
		arst_n <= 1'b1;
		cmd(6'h0C, 32'h0, 16'h0001);
		cmd(6'h07, 32'h0001_0000, 16'h1000);
		cmd(6'h06, 32'h03B7_0300, 16'h1020);
		cmd(6'h11, 32'h0100_0000, 16'h1002);
		cmd(6'h10, 32'h1, 16'h1000);
		cmd(6'h11, 32'h0, 16'h1004);
		@(posedge core_clk) partial_read_allowed <= 1'b1;
		cmd(6'h11, 32'h0, 16'h1100);
		frame(3'h0, 6'h1B, {5'h0, 2'b10, 8'hA5, crc16(8'hA5), 1'b1});
		cmd(6'h17, 32'h1, 16'h1000);
		cmd(6'h12, 32'h1, 16'h1100);
		frame(3'h0, 6'h1B, {5'h0, 2'b10, 8'hA6, crc16(8'hA6), 1'b1});
		cmd(6'h0C, 32'h0, 16'h1001);
		cmd(6'h17, 32'h0, 16'h1000);
		cmd(6'h12, 32'h2, 16'h1100);
		frame(3'h0, 6'h1B, {5'h0, 2'b10, 8'hA7, crc16(8'hA7), 1'b1});
		cmd(6'h0C, 32'h0, 16'h1000);
		// eight lines: top line carries bit 7 of the next source byte, 0xA8
		cmd(6'h06, 32'h03B7_0200, 16'h1000);
		cmd(6'h11, 32'h0, 16'h1100);
		frame(3'h7, 6'h14, {12'h0, 2'b10, 1'b1, 16'h1021, 1'b1});
		cmd(6'h06, 32'h03B7_0000, 16'h1000);
		// soft reset deselects, so a read after it is illegal
		cmd(6'h00, 32'h0, 16'h0000);
		cmd(6'h11, 32'h0, 16'h0001);
		conclude;
	end
endmodule // cbt_block_transfer_tb
